// File: hw/flash_serial_pkg.sv
package flash_serial_pkg;

	// array geometry
	localparam int unsigned WORDS       = 512;
	localparam int unsigned ADDR_W      = 9;
	localparam int unsigned DATA_W      = 16;
	localparam int unsigned SECTOR_BIT  = 8;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;

	// clock and oscillator timing
	localparam int unsigned ACLK_KHZ       = 40000;
	localparam int unsigned INT_OSC_KHZ    = 20000;
	localparam int unsigned OSC_DIV        = 4;
	localparam int unsigned OSC_OUT_KHZ    = INT_OSC_KHZ / OSC_DIV;
	localparam int unsigned OSC_HALF_CYC   = ACLK_KHZ / OSC_OUT_KHZ / 2;
	localparam int unsigned PROG_CYC_DEF   = 64;
	localparam int unsigned ERASE_CYC_DEF  = 256;

	// register map (byte addresses)
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] DATA_OFS   = 8'h08;

	// field positions
	localparam int unsigned CTRL_REPROG_BIT  = 0;
	localparam int unsigned STAT_BUSY_BIT    = 0;
	localparam int unsigned STAT_REPROG_BIT  = 1;
	localparam int unsigned STAT_ADDR_LSB    = 16;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_PROG  = 3'b010,
		ST_ERASE = 3'b100
	} seq_state_t;

	// axi4-lite master to slave
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axil_req_t;

	// axi4-lite slave to master
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_t;

	// user-logic pins sampled into aclk
	typedef struct packed {
		logic addr_reg_clock;
		logic addr_shift_select;
		logic addr_serial_in;
		logic data_reg_clock;
		logic data_shift_select;
		logic data_serial_in;
		logic program_req;
		logic erase_req;
		logic osc_enable;
	} pins_t;

endpackage : flash_serial_pkg

// File: hw/user_flash_serial_access.sv
`timescale 1ns/100ps
// Summary of operation
// - 512 x 16 array, 9-bit address register
// - address msb selects sector zero or one
// - erase clears whole sector chosen by msb
// - shift select high: address clock shifts bit
// - shift select low: address clock increments
// - all operations use current address register
// - 16-bit data register, serial in/out
// - data shift high: shift toward serial out
// - data shift low: parallel load addressed word
// - after load, msb appears first at output
// - rising program/erase request starts sequence
// - program ANDs data register into addressed word
// - only sector erase, no word erase
// - busy high from start to completion
// - osc output toggles when enabled, else low
// - osc output is quarter internal oscillator
// - oscillator runs itself during live reprogramming, not at power-up
// - osc toggles during live reprogramming regardless
// - requests ignored while busy; no clocking then
// - address increment wraps max to zero
// - shifted-in bit enters data register lsb
module user_flash_serial_access
	import flash_serial_pkg::*;
#(
	parameter int unsigned PROG_CYCLES  = PROG_CYC_DEF,
	parameter int unsigned ERASE_CYCLES = ERASE_CYC_DEF
) (
	input  wire logic      aclk,
	input  wire logic      aresetn,
	input  wire axil_req_t axil_req,
	output axil_rsp_t      axil_rsp,
	input  wire pins_t     pins,
	output logic           data_serial_out,
	output logic           busy,
	output logic           osc_out,
	output logic           live_reprog_busy
);

	// counter width covers the longest erase and the oscillator divider
	localparam int unsigned CNT_W = 16;

	// flash storage, not cleared by reset (nonvolatile)
	logic [DATA_W-1:0] mem_q [WORDS];

	// synchronisers and edge history
	pins_t             sync1_q;           // first stage, read only by sync2
	pins_t             sync2_q;           // usable level
	pins_t             sync3_q;           // previous level for edges

	// serial registers
	logic [ADDR_W-1:0] addr_q;            // address register
	logic [DATA_W-1:0] data_q;            // data register

	// sequencer
	seq_state_t        state_q;           // current state
	logic [CNT_W-1:0]  cnt_q;             // cycles left in operation
	logic [ADDR_W-1:0] op_addr_q;         // location latched at start
	logic [DATA_W-1:0] op_data_q;         // word latched at start

	// oscillator
	logic [CNT_W-1:0]  osc_cnt_q;         // half-period counter
	logic              osc_q;             // divided output

	// control register
	logic              reprog_q;          // live reprogramming request

	// axi slave state
	logic              aw_have_q;         // write address captured
	logic [7:0]        aw_addr_q;         // captured write address
	logic              w_have_q;          // write data captured
	logic [31:0]       w_data_q;          // captured write data
	logic [3:0]        w_strb_q;          // captured strobes
	axil_rsp_t         rsp_q;             // registered response

	// edges of sampled pins
	wire logic ar_edge   = sync2_q.addr_reg_clock & ~sync3_q.addr_reg_clock;
	wire logic dr_edge   = sync2_q.data_reg_clock & ~sync3_q.data_reg_clock;
	wire logic prog_edge = sync2_q.program_req & ~sync3_q.program_req;
	wire logic er_edge   = sync2_q.erase_req & ~sync3_q.erase_req;

	// serial registers are frozen while an operation or reprogramming runs
	wire logic regs_frozen = (state_q != ST_IDLE) | reprog_q;

	// request acceptance, program takes priority on a tie
	wire logic idle       = (state_q == ST_IDLE) & ~reprog_q;
	wire logic start_prog = idle & prog_edge;
	wire logic start_er   = idle & er_edge & ~prog_edge;

	// next register values
	wire logic [ADDR_W-1:0] addr_shifted = {addr_q[ADDR_W-2:0], sync2_q.addr_serial_in};
	wire logic [ADDR_W-1:0] addr_inc     = addr_q + 9'h001;
	wire logic [DATA_W-1:0] data_shifted = {data_q[DATA_W-2:0], sync2_q.data_serial_in};
	wire logic [DATA_W-1:0] data_loaded  = mem_q[addr_q];

	// oscillator gating
	wire logic osc_run = sync2_q.osc_enable | reprog_q;

	// axi decode
	wire logic aw_hs     = axil_req.awvalid & rsp_q.awready;
	wire logic w_hs      = axil_req.wvalid & rsp_q.wready;
	wire logic b_hs      = rsp_q.bvalid & axil_req.bready;
	wire logic ar_hs     = axil_req.arvalid & rsp_q.arready;
	wire logic r_hs      = rsp_q.rvalid & axil_req.rready;
	wire logic wr_do     = aw_have_q & w_have_q & ~rsp_q.bvalid;
	wire logic wr_ctrl   = wr_do & (aw_addr_q == CTRL_OFS);
	wire logic rd_hit    = (axil_req.araddr == CTRL_OFS) | (axil_req.araddr == STATUS_OFS)
	                       | (axil_req.araddr == DATA_OFS);

	// read data multiplexer
	function automatic logic [31:0] read_word(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			// control: live reprogramming request
			CTRL_OFS: begin
				r[CTRL_REPROG_BIT] = reprog_q;
			end
			// status: busy, live bit, address register
			STATUS_OFS: begin
				r[STAT_BUSY_BIT]                          = busy;
				r[STAT_REPROG_BIT]                        = live_reprog_busy;
				r[STAT_ADDR_LSB +: ADDR_W]                = addr_q;
			end
			// data register image
			DATA_OFS: begin
				r[DATA_W-1:0] = data_q;
			end
			// unmapped offsets read as zero
			default: begin
				r = 32'h0000_0000;
			end
		endcase
		return r;
	endfunction : read_word

	// two-stage sampling of all pins
	// only the second stage feeds logic; the third keeps history for edges
	always_ff @(posedge aclk) begin
		sync1_q <= pins;
		sync2_q <= sync1_q;
		sync3_q <= sync2_q;
	end

	// address register, shift or increment on its clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// power-up contents are unspecified, start from zero
			addr_q <= '0;
		end else if (ar_edge && !regs_frozen) begin
			// edges while frozen are dropped, not queued
			addr_q <= sync2_q.addr_shift_select ? addr_shifted : addr_inc;
		end
	end

	// data register, shift or parallel load on its clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// power-up contents are unspecified, start from zero
			data_q <= '0;
		end else if (dr_edge && !regs_frozen) begin
			// edges while frozen are dropped, not queued
			data_q <= sync2_q.data_shift_select ? data_shifted : data_loaded;
		end
	end

	// serial output is always the register msb
	// one cycle behind the register, like the other outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_serial_out <= 1'b0;
		end else begin
			data_serial_out <= data_q[DATA_W-1];
		end
	end

	// program/erase sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q   <= ST_IDLE;
			cnt_q     <= '0;
			op_addr_q <= '0;
			op_data_q <= '0;
		end else begin
			unique case (state_q)
				// idle: track location and word so a start uses them
				ST_IDLE: begin
					op_addr_q <= addr_q;
					op_data_q <= data_q;
					if (start_prog) begin
						state_q <= ST_PROG;
						cnt_q   <= CNT_W'(PROG_CYCLES - 1);
					end else if (start_er) begin
						// whole sector, chosen by the latched msb
						state_q <= ST_ERASE;
						cnt_q   <= CNT_W'(ERASE_CYCLES - 1);
					end
				end
				// count down, leave on the last cycle
				ST_PROG, ST_ERASE: begin
					if (cnt_q == '0) begin
						state_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q - 16'h0001;
					end
				end
			endcase
		end
	end

	// array update at the end of an operation
	// nonvolatile: no reset branch, erase before first use
	// programming can only clear bits, erase sets them all
	always_ff @(posedge aclk) begin
		for (int i = 0; i < WORDS; i++) begin
			if (state_q == ST_ERASE && cnt_q == '0 &&
			    i[SECTOR_BIT] == op_addr_q[SECTOR_BIT]) begin
				mem_q[i] <= ERASED_WORD;
			end else if (state_q == ST_PROG && cnt_q == '0 && i == int'(op_addr_q)) begin
				mem_q[i] <= mem_q[i] & op_data_q;
			end
		end
	end

	// busy follows the sequencer, raised on the start edge
	// falls on the cycle the array is written
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
		end else begin
			busy <= start_prog | start_er |
			        ((state_q != ST_IDLE) && cnt_q != '0);
		end
	end

	// divided oscillator output
	// gated off: output low and phase restarted, so the first
	// low phase after enabling is a full half period
	always_ff @(posedge aclk) begin
		if (!aresetn || !osc_run) begin
			osc_cnt_q <= '0;
			osc_q     <= 1'b0;
		end else if (osc_cnt_q == CNT_W'(OSC_HALF_CYC - 1)) begin
			osc_cnt_q <= '0;
			osc_q     <= ~osc_q;
		end else begin
			// count toward the half period
			osc_cnt_q <= osc_cnt_q + 16'h0001;
		end
	end

	// oscillator pin register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_out <= 1'b0;
		end else begin
			osc_out <= osc_q;
		end
	end

	// live reprogramming control bit and its busy output
	// only byte lane zero carries the control bit
	// the busy output trails the bit by one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reprog_q         <= 1'b0;
			live_reprog_busy <= 1'b0;
		end else begin
			if (wr_ctrl && w_strb_q[0]) begin
				reprog_q <= w_data_q[CTRL_REPROG_BIT];
			end
			live_reprog_busy <= reprog_q;
		end
	end

	// axi write address and data capture
	// each channel is held until the response handshake
	// so one write at most is under way
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
		end else begin
			if (aw_hs) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= axil_req.awaddr;
			end else if (b_hs) begin
				aw_have_q <= 1'b0;
			end
			if (w_hs) begin
				w_have_q <= 1'b1;
				w_data_q <= axil_req.wdata;
				w_strb_q <= axil_req.wstrb;
			end else if (b_hs) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// axi response channels
	// readies drop when a channel is taken and return after
	// its response; unmapped offsets answer with an error
	// read data is captured in the cycle the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsp_q <= '{awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
			           arready: 1'b1, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: RESP_OKAY};
		end else begin
			if (aw_hs) begin
				rsp_q.awready <= 1'b0;
			end else if (b_hs) begin
				rsp_q.awready <= 1'b1;
			end
			if (w_hs) begin
				rsp_q.wready <= 1'b0;
			end else if (b_hs) begin
				rsp_q.wready <= 1'b1;
			end
			if (wr_do) begin
				rsp_q.bvalid <= 1'b1;
				rsp_q.bresp  <= (aw_addr_q == CTRL_OFS) ? RESP_OKAY : RESP_SLVERR;
			end else if (b_hs) begin
				rsp_q.bvalid <= 1'b0;
			end
			if (ar_hs) begin
				rsp_q.arready <= 1'b0;
				rsp_q.rvalid  <= 1'b1;
				rsp_q.rdata   <= read_word(axil_req.araddr);
				rsp_q.rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (r_hs) begin
				rsp_q.arready <= 1'b1;
				rsp_q.rvalid  <= 1'b0;
			end
		end
	end

	// response channels straight from the register
	assign axil_rsp = rsp_q;

endmodule : user_flash_serial_access

// File: dv/user_flash_serial_access_asserts.sv
`timescale 1ns/100ps
// bus, busy and oscillator timing checks
module user_flash_serial_access_asserts
	import flash_serial_pkg::*;
#(
	parameter int unsigned PROG_CYCLES  = PROG_CYC_DEF,
	parameter int unsigned ERASE_CYCLES = ERASE_CYC_DEF
) (
	input wire logic      aclk,
	input wire logic      aresetn,
	input wire axil_req_t axil_req,
	input wire axil_rsp_t axil_rsp,
	input wire pins_t     pins,
	input wire logic      data_serial_out,
	input wire logic      busy,
	input wire logic      osc_out,
	input wire logic      live_reprog_busy
);
	logic [15:0] busy_len_q; // length of busy pulse
	// count busy cycles, clear while idle
	always_ff @(posedge aclk) begin
		if (!aresetn || !busy) busy_len_q <= 16'h0000;
		else busy_len_q <= busy_len_q + 16'h0001;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_wr_resp;
		axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready |-> ##2 axil_rsp.bvalid
			&& axil_rsp.bresp == (($past(axil_req.awaddr, 2) == CTRL_OFS) ? RESP_OKAY : RESP_SLVERR);
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late or wrong");
	property p_b_hold;
		axil_rsp.bvalid && !axil_req.bready |=> axil_rsp.bvalid && $stable(axil_rsp.bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_op_start;
		($rose(pins.program_req) || $rose(pins.erase_req)) && !busy && !live_reprog_busy |-> ##[2:6] busy;
	endproperty
	a_op_start: assert property (p_op_start) else $error("busy did not follow request");
	property p_busy_len;
		$fell(busy) |-> busy_len_q == PROG_CYCLES || busy_len_q == ERASE_CYCLES;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy pulse length wrong");
	property p_busy_frozen;
		busy && $past(busy) && $past(busy, 2) |-> $stable(data_serial_out);
	endproperty
	a_busy_frozen: assert property (p_busy_frozen) else $error("data moved while busy");
	property p_osc_off;
		(!pins.osc_enable && !live_reprog_busy) [*8] |-> !osc_out;
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("oscillator not held low");
	property p_osc_half;
		$rose(osc_out) |-> !$past(osc_out, 2) && !$past(osc_out, 4);
	endproperty
	a_osc_half: assert property (p_osc_half) else $error("oscillator low phase short");
	property p_reprog_osc;
		$rose(live_reprog_busy) |-> ##[1:12] $rose(osc_out);
	endproperty
	a_reprog_osc: assert property (p_reprog_osc) else $error("no oscillator in reprogramming");
endmodule : user_flash_serial_access_asserts

// File: dv/flash_user_logic_model.sv
`timescale 1ns/100ps
// far-side user logic, register clocks at 5 MHz
module flash_user_logic_model
	import flash_serial_pkg::*;
(
	input  wire logic aclk,
	input  wire logic busy,
	input  wire logic live_reprog_busy,
	input  wire logic data_serial_out,
	output pins_t     pins
);
	// all idle low, clocks stand still
	initial begin
		pins = '0;
	end
	// one clock pulse, 3 cycles low with levels set, 4 cycles high
	task automatic pulse(input logic to_data, input logic sel, input logic din);
		wait (!busy && !live_reprog_busy);
		@(posedge aclk);
		pins.addr_shift_select <= sel;
		pins.data_shift_select <= sel;
		pins.addr_serial_in    <= din;
		pins.data_serial_in    <= din;
		repeat (3) @(posedge aclk);
		pins.data_reg_clock <= to_data;
		pins.addr_reg_clock <= !to_data;
		repeat (4) @(posedge aclk);
		pins.data_reg_clock <= 1'b0;
		pins.addr_reg_clock <= 1'b0;
		pins.addr_serial_in <= !din;
		pins.data_serial_in <= !din;
	endtask : pulse
	// n bits msb first, address loaded before use
	task automatic shift_bits(input logic to_data, input logic [15:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			pulse(to_data, 1'b1, v[i]);
		end
	endtask : shift_bits
	// select low: increment or parallel load
	task automatic step(input logic to_data);
		pulse(to_data, 1'b0, 1'b0);
	endtask : step
	// load word, shift it out msb first
	task automatic read_word(output logic [15:0] w);
		step(1'b1);
		for (int i = 15; i >= 0; i--) begin
			@(negedge aclk);
			w[i] = data_serial_out;
			if (i > 0) pulse(1'b1, 1'b1, 1'b0);
		end
	endtask : read_word
	// program or erase, oscillator enabled meanwhile
	// poke (erase only): program request and data clock while busy
	task automatic start_op(input logic erase, input logic poke);
		wait (!busy && !live_reprog_busy);
		@(posedge aclk);
		pins.osc_enable  <= 1'b1;
		pins.erase_req   <= erase;
		pins.program_req <= !erase;
		repeat (8) @(posedge aclk);
		pins.erase_req         <= 1'b0;
		pins.program_req       <= poke;
		pins.data_shift_select <= 1'b1;
		pins.data_reg_clock    <= poke;
		repeat (4) @(posedge aclk);
		pins.program_req    <= 1'b0;
		pins.data_reg_clock <= 1'b0;
		wait (!busy);
		@(posedge aclk);
		pins.osc_enable <= 1'b0;
	endtask : start_op
endmodule : flash_user_logic_model

// File: dv/tb_user_flash_serial_access.sv
`timescale 1ns/100ps
// random programs and reads, address and bus corners
module tb_user_flash_serial_access
	import flash_serial_pkg::*;
;
	localparam int unsigned PROG_N  = 8;  // short program
	localparam int unsigned ERASE_N = 16; // short erase
	logic        aclk, aresetn;
	axil_req_t   axil_req;
	axil_rsp_t   axil_rsp;
	pins_t       pins;
	logic        data_serial_out, busy, osc_out, live_reprog_busy;
	int          bad_count, cmp_count;
	logic [15:0] shadow [0:511]; // expected array
	logic [31:0] rd;
	logic [1:0]  rr;
	logic [8:0]  a;
	logic [15:0] d;
	int          osc_rises; // oscillator rising edges seen
	logic        osc_prev;  // previous oscillator sample
	user_flash_serial_access #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N)) DUT (.aclk(aclk),
		.aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp), .pins(pins), .busy(busy),
		.data_serial_out(data_serial_out), .osc_out(osc_out), .live_reprog_busy(live_reprog_busy));
	flash_user_logic_model u_ctrl (.aclk(aclk), .busy(busy), .live_reprog_busy(live_reprog_busy),
		.data_serial_out(data_serial_out), .pins(pins));
	// 25 ns clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// write, each channel released when taken
	task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] resp);
		logic aw_t, w_t;
		@(posedge aclk);
		axil_req.awaddr  <= ad;
		axil_req.wdata   <= dt;
		axil_req.wstrb   <= 4'hF;
		axil_req.awvalid <= 1'b1;
		axil_req.wvalid  <= 1'b1;
		axil_req.bready  <= 1'b1;
		do begin
			@(negedge aclk);
			aw_t = axil_req.awvalid && axil_rsp.awready;
			w_t  = axil_req.wvalid && axil_rsp.wready;
			@(posedge aclk);
			if (aw_t) axil_req.awvalid <= 1'b0;
			if (w_t) axil_req.wvalid <= 1'b0;
		end while (axil_req.awvalid || axil_req.wvalid);
		do @(negedge aclk); while (!axil_rsp.bvalid);
		resp = axil_rsp.bresp;
		@(posedge aclk);
		axil_req.bready <= 1'b0;
	endtask : axi_wr
	// read one word
	task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] resp);
		@(posedge aclk);
		axil_req.araddr  <= ad;
		axil_req.arvalid <= 1'b1;
		axil_req.rready  <= 1'b1;
		do @(negedge aclk); while (!axil_rsp.arready);
		@(posedge aclk);
		axil_req.arvalid <= 1'b0;
		do @(negedge aclk); while (!axil_rsp.rvalid);
		dt   = axil_rsp.rdata;
		resp = axil_rsp.rresp;
		@(posedge aclk);
		axil_req.rready <= 1'b0;
	endtask : axi_rd
	// status word: address, live bit, idle
	function automatic logic [31:0] exp_status(input logic rb, input logic [8:0] ad);
		return {7'h00, ad, 14'h0000, rb, 1'b0};
	endfunction : exp_status
	task automatic status(input logic rb, input logic [8:0] ad);
		axi_rd(STATUS_OFS, rd, rr);
		chk("status", exp_status(rb, ad), rd);
	endtask : status
	// program a word, bits only cleared
	task automatic prog(input logic [8:0] ad, input logic [15:0] dt);
		u_ctrl.shift_bits(1'b0, {7'h00, ad}, 9);
		u_ctrl.shift_bits(1'b1, dt, 16);
		u_ctrl.start_op(1'b0, 1'b0);
		shadow[ad] = shadow[ad] & dt;
	endtask : prog
	// erase sector, low address bits junk
	task automatic erase(input logic s, input logic poke);
		u_ctrl.shift_bits(1'b0, {7'h00, s, 8'h5A}, 9);
		u_ctrl.start_op(1'b1, poke);
		for (int i = 0; i < 256; i++) shadow[{s, 8'(i)}] = 16'hFFFF;
	endtask : erase
	// serial read and compare
	task automatic rdw(input logic [8:0] ad, input logic load);
		logic [15:0] w;
		if (load) u_ctrl.shift_bits(1'b0, {7'h00, ad}, 9);
		u_ctrl.read_word(w);
		chk("word", {16'h0000, shadow[ad]}, {16'h0000, w});
	endtask : rdw
	// verdict and end of run
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	// main sequence
	initial begin
		axil_req  = '0;
		aresetn   = 1'b0;
		bad_count = 0;
		cmp_count = 0;
		rd = $urandom(32'h20CB);
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		status(1'b0, 9'h000);
		u_ctrl.shift_bits(1'b0, 16'h01FF, 9);
		status(1'b0, 9'h1FF);
		u_ctrl.step(1'b0);
		status(1'b0, 9'h000);
		d = 16'($urandom);
		u_ctrl.shift_bits(1'b1, d, 16);
		axi_rd(DATA_OFS, rd, rr);
		chk("data shift", {16'h0000, d}, rd);
		chk("serial out", 32'(d[15]), 32'(data_serial_out));
		erase(1'b0, 1'b1);
		axi_rd(DATA_OFS, rd, rr);
		chk("frozen data", {16'h0000, d}, rd);
		rdw(9'h05A, 1'b1);
		erase(1'b1, 1'b0);
		// random words, programmed twice, other sector erased
		repeat (3) begin
			a = 9'($urandom_range(0, 511));
			prog(a, 16'($urandom));
			prog(a, 16'($urandom));
			rdw(a, 1'b1);
			erase(~a[8], 1'b0);
			rdw(a, 1'b1);
		end
		// stream read across the sector boundary
		prog(9'h0FF, 16'($urandom));
		prog(9'h100, 16'($urandom));
		rdw(9'h0FF, 1'b1);
		u_ctrl.step(1'b0);
		rdw(9'h100, 1'b0);
		axi_wr(8'h0C, 32'h1, rr);
		chk("bad write", 32'(RESP_SLVERR), 32'(rr));
		axi_rd(8'h10, rd, rr);
		chk("bad read", 32'h0, rd);
		chk("bad read resp", 32'(RESP_SLVERR), 32'(rr));
		axi_wr(CTRL_OFS, 32'h1, rr);
		chk("ctrl write resp", 32'(RESP_OKAY), 32'(rr));
		axi_rd(CTRL_OFS, rd, rr);
		chk("ctrl read", 32'h1, rd);
		status(1'b1, 9'h100);
		osc_rises = 0;
		@(negedge aclk);
		osc_prev = osc_out;
		repeat (40) begin
			@(negedge aclk);
			if (osc_out && !osc_prev) osc_rises++;
			osc_prev = osc_out;
		end
		chk("osc rises", 32'(40 / (2 * OSC_HALF_CYC)), 32'(osc_rises));
		axi_wr(CTRL_OFS, 32'h0, rr);
		status(1'b0, 9'h100);
		repeat (4) @(posedge aclk);
		chk("osc held low", 32'h0, 32'(osc_out));
		finish_test();
	end
	// hang guard
	initial begin
		#400000;
		bad_count++;
		finish_test();
	end
endmodule : tb_user_flash_serial_access

bind user_flash_serial_access user_flash_serial_access_asserts #(.PROG_CYCLES(PROG_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES)) u_chk (.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
	.axil_rsp(axil_rsp), .pins(pins), .data_serial_out(data_serial_out), .busy(busy),
	.osc_out(osc_out), .live_reprog_busy(live_reprog_busy));
